// ===== rtl/cbx_pkg.sv
// Package of constants, types and the register map for the branch and bit-clear executor
package cbx_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_FLAGS = 8'h04;
    localparam logic [7:0] OFF_BANK = 8'h08;
    localparam logic [7:0] OFF_INDEX = 8'h0c;
    localparam logic [7:0] OFF_PC = 8'h10;
    localparam logic [7:0] OFF_INSTR = 8'h14;
    localparam logic [7:0] OFF_EXST = 8'h18;
    localparam logic [7:0] OFF_MADDR = 8'h1c;
    localparam logic [7:0] OFF_MDATA = 8'h20;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_EXT_POS = 0;
    localparam int FLAG_CARRY_POS = 0;
    localparam int FLAG_NEG_POS = 4;
    localparam int EXST_BUSY_POS = 0;
    localparam int EXST_TAKEN_POS = 1;
    localparam int EXST_UNK_POS = 2;
    localparam int EXST_REF_POS = 3;
    localparam int EXST_CYC_POS = 8;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic RST_EXT = 1'b0;
    localparam logic [3:0] RST_BANK = 4'h0;
    localparam logic [11:0] RST_INDEX = 12'h000;
    localparam logic [20:0] RST_PC = 21'h000000;

    // ----------------------------------------
    // Encodings and timing
    // ----------------------------------------
    localparam logic [7:0] OPC_BR_CARRY = 8'he2;
    localparam logic [7:0] OPC_BR_NEG = 8'he6;
    localparam logic [3:0] OPC_CLR_BIT = 4'h9;
    localparam logic [7:0] INDEXED_MAX = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam int Q_PHASES = 4;
    localparam logic [7:0] CYC_NOT_TAKEN = 8'h01;
    localparam logic [7:0] CYC_TAKEN = 8'h02;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_FLUSH = 3'b100
    } cbx_state_t;

    typedef enum logic [3:0] {
        OP_NONE = 4'b0001,
        OP_BRC = 4'b0010,
        OP_BRN = 4'b0100,
        OP_CLR = 4'b1000
    } cbx_op_t;

    typedef struct packed {
        cbx_op_t op;
        logic [7:0] offset;
        logic [2:0] bit_sel;
        logic access_bank_n;
        logic [7:0] file;
    } cbx_dec_t;

endpackage

// ===== rtl/cbx_qphase.sv
// Four-phase instruction cycle enable generator
`timescale 1ns/1ps
module cbx_qphase (
    input wire logic core_clk,
    input wire logic rstn,
    output logic [3:0] q_en
);
    import cbx_pkg::*;

    // ----------------------------------------
    // Phase counter
    // ----------------------------------------
    logic [1:0] cnt_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 2'h0;
        end else if (cnt_q == 2'(Q_PHASES - 1)) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end

    // ----------------------------------------
    // One-cycle phase pulses
    // ----------------------------------------
    always_comb begin
        q_en = 4'h0;
        q_en[cnt_q] = 1'b1;
    end

endmodule

// ===== rtl/cbx_exec.sv
// Branch and bit-clear executor with AXI4-Lite register access
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module cbx_exec (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic exec_busy,
    output logic [20:0] pc_out
);
    import cbx_pkg::*;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic cbx_dec_t decode(input logic [15:0] w);
        cbx_dec_t d;
        d.op = OP_NONE;
        d.offset = w[7:0];
        d.bit_sel = w[11:9];
        d.access_bank_n = w[8];
        d.file = w[7:0];
        if (w[15:8] == OPC_BR_NEG) begin
            d.op = OP_BRN;
        end else if (w[15:8] == OPC_BR_CARRY) begin
            d.op = OP_BRC;
        end else if (w[15:12] == OPC_CLR_BIT) begin
            d.op = OP_CLR;
        end
        return d;
    endfunction

    function automatic logic [11:0] eff_addr(input cbx_dec_t d, input logic ext,
                                             input logic [3:0] bank, input logic [11:0] base);
        logic [11:0] a;
        a = {bank, d.file};
        if (!d.access_bank_n) begin
            if (ext && d.file <= INDEXED_MAX) begin
                a = base + {4'h0, d.file};
            end else if (d.file < ACCESS_SPLIT) begin
                a = {4'h0, d.file};
            end else begin
                a = {ACCESS_HI_BANK, d.file};
            end
        end
        return a;
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [3:0] q_en;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_held_q;
    logic w_held_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_fire;
    logic wr_err;
    logic ext_q;
    logic carry_q;
    logic neg_q;
    logic [3:0] bank_q;
    logic [11:0] index_q;
    logic [20:0] pc_q;
    logic [15:0] instr_q;
    logic pending_q;
    logic busy_q;
    logic taken_q;
    logic unknown_q;
    logic refused_q;
    logic [7:0] cycles_q;
    logic [11:0] maddr_q;
    cbx_state_t state_q;
    cbx_dec_t dec_q;
    logic [11:0] ea_q;
    logic [7:0] data_q;
    logic branch_cond;
    logic [20:0] br_disp;
    logic [7:0] dmem [0:4095];
    logic busy_now;
    logic instr_wr;
    logic [31:0] wr_word;
    logic awready_q;
    logic wready_q;
    logic [31:0] ext_m, bank_m, index_m, maddr_m, instr_m, pc_m;

    cbx_qphase u_qphase (
        .core_clk(core_clk),
        .rstn(rstn),
        .q_en(q_en)
    );

    assign busy_now = pending_q || (state_q != ST_IDLE);
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign wr_err = busy_now && (awaddr_q == OFF_PC || awaddr_q == OFF_MDATA);
    assign instr_wr = wr_fire && awaddr_q == OFF_INSTR;
    assign wr_word = merge_strb(32'h00000000, wdata_q, wstrb_q);
    assign ext_m = merge_strb({31'h0, ext_q}, wdata_q, wstrb_q);
    assign bank_m = merge_strb({28'h0, bank_q}, wdata_q, wstrb_q);
    assign index_m = merge_strb({20'h0, index_q}, wdata_q, wstrb_q);
    assign maddr_m = merge_strb({20'h0, maddr_q}, wdata_q, wstrb_q);
    assign instr_m = merge_strb({16'h0, instr_q}, wdata_q, wstrb_q);
    assign pc_m = merge_strb({11'h0, pc_q}, wdata_q, wstrb_q);

    // ----------------------------------------
    // AXI write channels
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b1;
            awaddr_q <= 8'h00;
        end else if (s_axi_awvalid && !aw_held_q) begin
            aw_held_q <= 1'b1;
            awready_q <= 1'b0;
            awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            w_held_q <= 1'b0;
            wready_q <= 1'b1;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && !w_held_q) begin
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            case (awaddr_q)
                OFF_CTRL, OFF_FLAGS, OFF_BANK, OFF_INDEX, OFF_INSTR, OFF_EXST,
                OFF_MADDR: begin
                    bresp_q <= RESP_OKAY;
                end
                OFF_PC, OFF_MDATA: begin
                    bresp_q <= wr_err ? RESP_SLVERR : RESP_OKAY;
                end
                default: begin
                    bresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ----------------------------------------
    // AXI read channel
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h00000000;
            case ({s_axi_araddr[7:2], 2'b00})
                OFF_CTRL: rdata_q[CTRL_EXT_POS] <= ext_q;
                OFF_FLAGS: begin
                    rdata_q[FLAG_CARRY_POS] <= carry_q;
                    rdata_q[FLAG_NEG_POS] <= neg_q;
                end
                OFF_BANK: rdata_q[3:0] <= bank_q;
                OFF_INDEX: rdata_q[11:0] <= index_q;
                OFF_PC: rdata_q[20:0] <= pc_q;
                OFF_INSTR: rdata_q[15:0] <= instr_q;
                OFF_EXST: begin
                    rdata_q[EXST_BUSY_POS] <= busy_now;
                    rdata_q[EXST_TAKEN_POS] <= taken_q;
                    rdata_q[EXST_UNK_POS] <= unknown_q;
                    rdata_q[EXST_REF_POS] <= refused_q;
                    rdata_q[EXST_CYC_POS +: 8] <= cycles_q;
                end
                OFF_MADDR: rdata_q[11:0] <= maddr_q;
                OFF_MDATA: rdata_q[7:0] <= dmem[maddr_q];
                default: rresp_q <= RESP_SLVERR;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ----------------------------------------
    // Software settings
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ext_q <= RST_EXT;
            bank_q <= RST_BANK;
            index_q <= RST_INDEX;
            maddr_q <= 12'h000;
        end else if (wr_fire) begin
            case (awaddr_q)
                OFF_CTRL: ext_q <= ext_m[CTRL_EXT_POS];
                OFF_BANK: bank_q <= bank_m[3:0];
                OFF_INDEX: index_q <= index_m[11:0];
                OFF_MADDR: maddr_q <= maddr_m[11:0];
                default: ;
            endcase
        end
    end

    // Flags are only ever written by software
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            carry_q <= 1'b0;
            neg_q <= 1'b0;
        end else if (wr_fire && awaddr_q == OFF_FLAGS && wstrb_q[0]) begin
            carry_q <= wdata_q[FLAG_CARRY_POS];
            neg_q <= wdata_q[FLAG_NEG_POS];
        end
    end

    // ----------------------------------------
    // Instruction issue
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            instr_q <= 16'h0000;
            pending_q <= 1'b0;
        end else if (instr_wr && !busy_now) begin
            instr_q <= instr_m[15:0];
            pending_q <= 1'b1;
        end else if (state_q == ST_IDLE && q_en[0]) begin
            pending_q <= 1'b0;
        end
    end

    // Sticky error bits, set wins over a write-one clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            refused_q <= 1'b0;
            unknown_q <= 1'b0;
        end else begin
            if (instr_wr && busy_now) begin
                refused_q <= 1'b1;
            end else if (wr_fire && awaddr_q == OFF_EXST && wr_word[EXST_REF_POS]) begin
                refused_q <= 1'b0;
            end
            if (state_q == ST_EXEC && q_en[2] && dec_q.op == OP_NONE) begin
                unknown_q <= 1'b1;
            end else if (wr_fire && awaddr_q == OFF_EXST && wr_word[EXST_UNK_POS]) begin
                unknown_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Execution sequencer
    // ----------------------------------------
    assign branch_cond = (dec_q.op == OP_BRN && neg_q)
        || (dec_q.op == OP_BRC && carry_q);
    assign br_disp = {{12{dec_q.offset[7]}}, dec_q.offset, 1'b0};

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            dec_q <= '{op: OP_NONE, offset: 8'h00, bit_sel: 3'h0, access_bank_n: 1'b0,
                       file: 8'h00};
            ea_q <= 12'h000;
            taken_q <= 1'b0;
            cycles_q <= 8'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (pending_q && q_en[0]) begin
                        dec_q <= decode(instr_q);
                        ea_q <= eff_addr(decode(instr_q), ext_q, bank_q, index_q);
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (q_en[3]) begin
                        taken_q <= branch_cond;
                        if (branch_cond) begin
                            cycles_q <= CYC_TAKEN;
                            state_q <= ST_FLUSH;
                        end else begin
                            cycles_q <= CYC_NOT_TAKEN;
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_FLUSH: begin
                    if (q_en[3]) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Program counter
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pc_q <= RST_PC;
        end else if (state_q == ST_IDLE && pending_q && q_en[0]) begin
            pc_q <= pc_q + PC_STEP;
        end else if (state_q == ST_EXEC && q_en[3] && branch_cond) begin
            pc_q <= pc_q + br_disp;
        end else if (wr_fire && awaddr_q == OFF_PC && !busy_now) begin
            pc_q <= {pc_m[20:1], 1'b0};
        end
    end

    // ----------------------------------------
    // Data memory and bit clear
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            data_q <= 8'h00;
        end else if (state_q == ST_EXEC && q_en[1]) begin
            data_q <= dmem[ea_q];
        end else if (state_q == ST_EXEC && q_en[2] && dec_q.op == OP_CLR) begin
            data_q <= data_q & ~(8'h01 << dec_q.bit_sel);
        end
    end

    always_ff @(posedge core_clk) begin
        if (state_q == ST_EXEC && q_en[3] && dec_q.op == OP_CLR) begin
            dmem[ea_q] <= data_q;
        end else if (wr_fire && awaddr_q == OFF_MDATA && !busy_now && wstrb_q[0]) begin
            dmem[maddr_q] <= wdata_q[7:0];
        end
    end

    // ----------------------------------------
    // Status outputs
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_now;
        end
    end

    assign exec_busy = busy_q;
    assign pc_out = pc_q;

endmodule

// ===== test/cbx_exec_properties.sv
// Port checks for the branch and bit-clear executor
`timescale 1ns/1ps
module cbx_exec_properties
    import cbx_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic exec_busy,
    input wire logic [20:0] pc_out
);
    // ----------------------------------------
    // Busy length counter
    // ----------------------------------------
    logic [4:0] busy_cnt_q;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy_cnt_q <= 5'h00;
        end else if (exec_busy) begin
            busy_cnt_q <= busy_cnt_q + 5'h01;
        end else begin
            busy_cnt_q <= 5'h00;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_pc_word_aligned: assert property (pc_out[0] == 1'b0)
        else $error("Counter not word aligned");
    a_pc_change_cause: assert property ($changed(pc_out) |-> exec_busy || s_axi_bvalid)
        else $error("Counter moved while idle");
    a_busy_span_bound: assert property (busy_cnt_q <= 5'h10)
        else $error("Execution busy too long");
    a_write_resp_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("Write response late");
    a_read_resp_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read response late");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("Read data dropped");
    a_read_no_overlap: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read address taken during response");
    a_slverr_zero_data: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
        |-> s_axi_rdata == 32'h0)
        else $error("Error read carries data");
endmodule

bind cbx_exec cbx_exec_properties i_props (.*);

// ===== test/tb_cbx_exec.sv
// Self-checking bench for the branch and bit-clear executor
`timescale 1ns/1ps
module tb_cbx_exec;
    import cbx_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic exec_busy;
    logic [20:0] pc_out;
    int failures = 0;
    int n_tests = 0;

    always #2 core_clk = ~core_clk;

    cbx_exec i_dut (.*);

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_p;
        logic w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge core_clk);
            if (aw_p && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_p && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                w_p = 1'b0;
            end
        end
        repeat (2) @(posedge core_clk);
        s_axi_bready <= 1'b1;
        do @(posedge core_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(s_axi_bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        @(posedge core_clk);
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk("rresp", 32'(s_axi_rresp), 32'(er));
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string what);
        logic [31:0] d;
        rd(a, d, RESP_OKAY);
        chk(what, d, e);
    endtask

    task automatic idle();
        logic [31:0] d;
        int k;
        k = 0;
        do begin
            rd(OFF_EXST, d, RESP_OKAY);
            k++;
        end while (d[EXST_BUSY_POS] !== 1'b0 && k < 40);
        chk("idle", 32'(d[EXST_BUSY_POS]), 32'h0);
    endtask

    task automatic run(input logic [15:0] ins);
        wr(OFF_INSTR, {16'h0, ins}, RESP_OKAY);
        idle();
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [31:0] d;
        rdc(OFF_PC, 32'h0, "pc after reset");
        rdc(OFF_CTRL, 32'h0, "ctrl after reset");
        rd(8'h24, d, RESP_SLVERR);
        chk("unmapped rdata", d, 32'h0);
        wr(8'h24, 32'h1, RESP_SLVERR);
    endtask

    task automatic t_clear();
        logic [47:0] tc [7];
        logic [47:0] c;
        logic [31:0] e;
        tc = '{48'h0_3_000_1_45_7_345, 48'h0_3_000_0_45_0_045, 48'h0_3_000_0_a0_3_fa0,
               48'h1_3_7f0_0_5f_5_84f, 48'h1_3_fe0_0_30_6_010, 48'h1_3_7f0_0_60_2_060,
               48'h1_5_7f0_1_10_1_510};
        foreach (tc[i]) begin
            c = tc[i];
            wr(OFF_CTRL, 32'(c[47:44]), RESP_OKAY);
            wr(OFF_BANK, 32'(c[43:40]), RESP_OKAY);
            wr(OFF_INDEX, 32'(c[39:28]), RESP_OKAY);
            wr(OFF_MADDR, 32'(c[11:0]), RESP_OKAY);
            wr(OFF_MDATA, 32'h0000_00ff, RESP_OKAY);
            run({4'h9, c[14:12], c[24], c[23:16]});
            e = 32'(8'hff & ~(8'h01 << c[14:12]));
            rdc(OFF_MDATA, e, "cleared byte");
        end
    endtask

    task automatic t_branch();
        logic [23:0] br [7];
        logic [31:0] d;
        logic [20:0] exp;
        logic [7:0] n;
        logic tk;
        br = '{24'he2_01_05, 24'he2_10_05, 24'he6_10_80, 24'he6_01_80, 24'he6_10_7f,
               24'he2_00_fb, 24'he6_11_fb};
        foreach (br[i]) begin
            n = br[i][7:0];
            tk = (br[i][23:16] == OPC_BR_CARRY) ? br[i][8 + FLAG_CARRY_POS]
                : br[i][8 + FLAG_NEG_POS];
            exp = 21'h000100 + PC_STEP + (tk ? {{12{n[7]}}, n, 1'b0} : 21'h0);
            wr(OFF_PC, 32'h0000_0100, RESP_OKAY);
            wr(OFF_FLAGS, 32'(br[i][15:8]), RESP_OKAY);
            run({br[i][23:16], n});
            chk("pc_out", 32'(pc_out), 32'(exp));
            rd(OFF_EXST, d, RESP_OKAY);
            chk("taken", 32'(d[EXST_TAKEN_POS]), 32'(tk));
            chk("cycles", 32'(d[EXST_CYC_POS +: 8]),
                32'(tk ? CYC_TAKEN : CYC_NOT_TAKEN));
            rdc(OFF_FLAGS, 32'(br[i][15:8]), "flags kept");
        end
    endtask

    task automatic t_busy();
        wr(OFF_PC, 32'h0000_0040, RESP_OKAY);
        wr(OFF_FLAGS, 32'h0000_0001, RESP_OKAY);
        wr(OFF_INSTR, 32'h0000_e202, RESP_OKAY);
        wr(OFF_PC, 32'h0000_0400, RESP_SLVERR);
        idle();
        rdc(OFF_PC, 32'h0000_0046, "pc after refused write");
    endtask

    task automatic t_sticky();
        wr(OFF_INSTR, 32'h0000_e202, RESP_OKAY);
        wr(OFF_INSTR, 32'h0000_0000, RESP_OKAY);
        idle();
        rdc(OFF_EXST, (32'(CYC_TAKEN) << EXST_CYC_POS) | (32'h1 << EXST_TAKEN_POS)
            | (32'h1 << EXST_REF_POS), "refused kept");
        wr(OFF_EXST, 32'h1 << EXST_REF_POS, RESP_OKAY);
        run(16'h0000);
        rdc(OFF_EXST, (32'(CYC_NOT_TAKEN) << EXST_CYC_POS) | (32'h1 << EXST_UNK_POS),
            "unknown flagged");
    endtask

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic final_report();
        $display("Checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_clear();
        t_branch();
        t_busy();
        t_sticky();
        final_report();
    end

    initial begin
        #40000;
        failures++;
        final_report();
    end
endmodule
